// ==== dmagc_alias_reg.sv ====
// One register with plain, clear, set and invert writes through one write port and a fixed writable mask.
module dmagc_alias_reg
  import dmagc_pkg::*;
#(
  parameter logic [31:0] WMASK = 32'hFFFF_FFFF
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_nrst,
  // Write request
  input wire logic i_we,
  input wire dmagc_pkg::dmagc_op_e i_op,
  input wire logic [31:0] i_wdata,
  // Stored value
  output logic [31:0] o_q
);
  logic [31:0] val_q;
  logic [31:0] val_d;

  always_comb begin
    val_d = val_q;
    if (i_we) begin
      case (i_op)
        DMAGC_OP_WRITE: val_d = (val_q & ~WMASK) | (i_wdata & WMASK);
        DMAGC_OP_CLR: val_d = val_q & ~(i_wdata & WMASK);
        DMAGC_OP_SET: val_d = val_q | (i_wdata & WMASK);
        DMAGC_OP_INV: val_d = val_q ^ (i_wdata & WMASK);
        default: val_d = val_q;
      endcase
    end
  end

  // Reset to zero; unimplemented bits never change because the mask keeps them out.
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      val_q <= DMAGC_ZERO;
    end else begin
      val_q <= val_d;
    end
  end

  assign o_q = val_q;
endmodule

// ==== dmagc_monitor.sv ====
// Checker on global control writes, busy flag, grant and read data.
module dmagc_monitor (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_sel,
  input wire logic i_wr,
  input wire logic [15:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_xfer_req,
  input wire logic i_xfer_active,
  input wire logic o_xfer_grant,
  input wire logic o_module_on,
  input wire logic o_suspend,
  input wire logic o_module_active_flag,
  input wire logic o_hit,
  input wire logic [31:0] o_rdata
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  sequence gw(a, b);
    i_sel && i_wr && i_addr == a && i_wdata[b];
  endsequence
  chk_grant_gate: assert property (o_xfer_grant == (i_xfer_req && o_module_on && !o_suspend))
    else $error("grant wrong");
  chk_set_on: assert property (gw(16'h3008, 15) |=> o_module_on)
    else $error("set alias failed");
  chk_clr_on: assert property (gw(16'h3004, 15) |=> !o_module_on)
    else $error("clear alias failed");
  chk_inv_on: assert property (gw(16'h300C, 15) |=> o_module_on != $past(o_module_on))
    else $error("invert alias failed");
  chk_susp_write: assert property (gw(16'h3000, 12) |=> o_suspend)
    else $error("suspend not stored");
  chk_busy_on: assert property (o_module_on |=> o_module_active_flag)
    else $error("busy low while on");
  chk_busy_idle: assert property (!o_module_on && !i_xfer_active |=> !o_module_active_flag)
    else $error("busy high while idle");
  chk_read_bits: assert property (i_sel && !i_wr && i_addr == 16'h3000 |=>
    o_rdata == {16'h0000, $past(o_module_on), 2'h0, $past(o_suspend), $past(o_module_active_flag), 11'h000})
    else $error("control read wrong");
  chk_hit_hole: assert property (i_sel && i_addr == 16'h3010 |-> !o_hit)
    else $error("hole mapped");
endmodule

// ==== dmagc_pkg.sv ====
// Register map, field positions and reset values for the DMA global control and CRC register bank.
package dmagc_pkg;

  localparam int unsigned DMAGC_AW = 16;
  localparam int unsigned DMAGC_DW = 32;

  // Base addresses of the register groups (low 16 bits of the peripheral address).
  localparam logic [15:0] DMAGC_GCTL_BASE = 16'h3000;
  localparam logic [15:0] DMAGC_CRCCTL_BASE = 16'h3030;
  localparam logic [15:0] DMAGC_CRCDATA_BASE = 16'h3040;
  localparam logic [15:0] DMAGC_CRCXOR_BASE = 16'h3050;

  // Alias offsets within a group of four words.
  localparam logic [3:0] DMAGC_OFS_PLAIN = 4'h0;
  localparam logic [3:0] DMAGC_OFS_CLR = 4'h4;
  localparam logic [3:0] DMAGC_OFS_SET = 4'h8;
  localparam logic [3:0] DMAGC_OFS_INV = 4'hC;

  // Global control field positions.
  localparam int unsigned DMAGC_ON_BIT = 15;
  localparam int unsigned DMAGC_SUSP_BIT = 12;
  localparam int unsigned DMAGC_BUSY_BIT = 11;

  // Writable masks and reset values.
  localparam logic [31:0] DMAGC_GCTL_WMASK = 32'h0000_9000;
  localparam logic [31:0] DMAGC_CRCCTL_WMASK = 32'h3900_1FE7;
  localparam logic [31:0] DMAGC_ZERO = 32'h0000_0000;
  localparam logic [31:0] DMAGC_ALL_ONES = 32'hFFFF_FFFF;

  // Address fields: byte-in-word bits and the alias offset within a group.
  localparam int unsigned DMAGC_ALIGN_W = 2;
  localparam int unsigned DMAGC_OFS_W = 4;
  localparam logic [1:0] DMAGC_ALIGN_ZERO = 2'h0;

  // Group indices, one register per group.
  localparam int unsigned DMAGC_NGRP = 4;
  localparam logic [1:0] DMAGC_GRP_GCTL = 2'h0;
  localparam logic [1:0] DMAGC_GRP_CRCCTL = 2'h1;
  localparam logic [1:0] DMAGC_GRP_CRCDATA = 2'h2;
  localparam logic [1:0] DMAGC_GRP_CRCXOR = 2'h3;

  typedef enum logic [1:0] {
    DMAGC_OP_WRITE = 2'b00,
    DMAGC_OP_CLR = 2'b01,
    DMAGC_OP_SET = 2'b10,
    DMAGC_OP_INV = 2'b11
  } dmagc_op_e;

endpackage

// ==== dmagc_top.sv ====
// DMA global control register and CRC register bank with clear, set and invert aliases.
module dmagc_top
  import dmagc_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_nrst,
  // Peripheral register port
  input wire logic i_sel,
  input wire logic i_wr,
  input wire logic [dmagc_pkg::DMAGC_AW-1:0] i_addr,
  input wire logic [dmagc_pkg::DMAGC_DW-1:0] i_wdata,
  output logic [dmagc_pkg::DMAGC_DW-1:0] o_rdata,
  output logic o_hit,
  // Channel engine handshake
  input wire logic i_xfer_req,
  input wire logic i_xfer_active,
  output logic o_xfer_grant,
  // Control outputs to the channel and CRC engines
  output logic o_module_on,
  output logic o_suspend,
  output logic o_module_active_flag,
  output logic [31:0] o_crc_control,
  output logic [31:0] o_crc_data,
  output logic [31:0] o_crc_xor_mask
);
  import dmagc_pkg::*;

  // Selects which register group an address belongs to.
  function automatic logic [1:0] grp_of(input logic [15:0] a);
    logic [1:0] g;
    g = DMAGC_GRP_GCTL;
    case ({a[DMAGC_AW-1:DMAGC_OFS_W], DMAGC_OFS_PLAIN})
      DMAGC_GCTL_BASE: g = DMAGC_GRP_GCTL;
      DMAGC_CRCCTL_BASE: g = DMAGC_GRP_CRCCTL;
      DMAGC_CRCDATA_BASE: g = DMAGC_GRP_CRCDATA;
      DMAGC_CRCXOR_BASE: g = DMAGC_GRP_CRCXOR;
      default: g = DMAGC_GRP_GCTL;
    endcase
    return g;
  endfunction

  // Only word-aligned addresses inside the four groups are mapped; anything else is refused.
  function automatic logic is_mapped(input logic [15:0] a);
    logic m;
    m = 1'b0;
    case ({a[DMAGC_AW-1:DMAGC_OFS_W], DMAGC_OFS_PLAIN})
      DMAGC_GCTL_BASE, DMAGC_CRCCTL_BASE, DMAGC_CRCDATA_BASE, DMAGC_CRCXOR_BASE: begin
        m = (a[DMAGC_ALIGN_W-1:0] == DMAGC_ALIGN_ZERO);
      end
      default: m = 1'b0;
    endcase
    return m;
  endfunction

  // Writable mask of each group; the read path applies it too, so unimplemented bits read zero except global control bit 11 (busy).
  function automatic logic [31:0] wmask_of(input logic [1:0] g);
    logic [31:0] w;
    w = DMAGC_ALL_ONES;
    case (g)
      DMAGC_GRP_GCTL: w = DMAGC_GCTL_WMASK;
      DMAGC_GRP_CRCCTL: w = DMAGC_CRCCTL_WMASK;
      default: w = DMAGC_ALL_ONES;
    endcase
    return w;
  endfunction

  // Access decode.
  logic hit;
  logic [1:0] grp;
  dmagc_op_e op;
  logic [DMAGC_NGRP-1:0] we;

  // Register contents, indexed by group.
  logic [31:0] gctl_q;
  logic [31:0] regs [DMAGC_NGRP];
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;

  // Activity tracker: RUN while enabled, DRAIN while a transfer is still active with the enable low.
  typedef enum logic [1:0] {
    DMAGC_ST_IDLE = 2'b00,
    DMAGC_ST_RUN = 2'b01,
    DMAGC_ST_DRAIN = 2'b10
  } dmagc_state_e;
  dmagc_state_e state_q;
  dmagc_state_e state_d;
  logic busy_q;

  assign hit = i_sel && is_mapped(i_addr);
  assign grp = grp_of(i_addr);
  assign o_hit = hit;

  // The low address nibble picks a plain, clear, set or invert write.
  always_comb begin
    case (i_addr[DMAGC_OFS_W-1:0])
      DMAGC_OFS_CLR: op = DMAGC_OP_CLR;
      DMAGC_OFS_SET: op = DMAGC_OP_SET;
      DMAGC_OFS_INV: op = DMAGC_OP_INV;
      default: op = DMAGC_OP_WRITE;
    endcase
  end

  // One write enable per group; a refused access raises none of them.
  genvar gi;
  generate
    for (gi = 0; gi < DMAGC_NGRP; gi++) begin : g_we
      assign we[gi] = hit && i_wr && (grp == 2'(gi));
    end
  endgenerate

  // Global control takes the same alias writes as the CRC bank.
  dmagc_alias_reg #(.WMASK(DMAGC_GCTL_WMASK)) u_gctl (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_we(we[0]),
    .i_op(op),
    .i_wdata(i_wdata),
    .o_q(gctl_q)
  );

  generate
    for (gi = 1; gi < 4; gi++) begin : g_crc
      dmagc_alias_reg #(.WMASK(gi == 1 ? DMAGC_CRCCTL_WMASK : 32'hFFFF_FFFF)) u_reg (
        .i_mclk(i_mclk),
        .i_nrst(i_nrst),
        .i_we(we[gi]),
        .i_op(op),
        .i_wdata(i_wdata),
        .o_q(regs[gi])
      );
    end
  endgenerate
  assign regs[0] = gctl_q;

  // Control bits go straight from the register flops to the engines.
  assign o_module_on = gctl_q[DMAGC_ON_BIT];
  assign o_suspend = gctl_q[DMAGC_SUSP_BIT];
  assign o_crc_control = regs[1];
  assign o_crc_data = regs[2];
  assign o_crc_xor_mask = regs[3];

  // A new transfer needs the module on and not suspended; one already running is left to finish.
  assign o_xfer_grant = i_xfer_req && o_module_on && !o_suspend;

  // Busy is up while the enable is set, and also while a transfer is still active with the enable low.
  always_comb begin
    state_d = state_q;
    case (state_q)
      DMAGC_ST_IDLE: begin
        if (o_module_on) begin
          state_d = DMAGC_ST_RUN;
        end else if (i_xfer_active) begin
          state_d = DMAGC_ST_DRAIN;
        end
      end
      DMAGC_ST_RUN: begin
        if (!o_module_on) begin
          state_d = i_xfer_active ? DMAGC_ST_DRAIN : DMAGC_ST_IDLE;
        end
      end
      // Enabling again during a drain goes straight back to running.
      DMAGC_ST_DRAIN: begin
        if (o_module_on) begin
          state_d = DMAGC_ST_RUN;
        end else if (!i_xfer_active) begin
          state_d = DMAGC_ST_IDLE;
        end
      end
      default: state_d = DMAGC_ST_IDLE;
    endcase
  end

  // The tracker starts idle, so the busy flag is low right after reset.
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q <= DMAGC_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // The flag is registered, so it rises one cycle after the enable and falls one cycle after enable and transfer are both low.
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= (state_d != DMAGC_ST_IDLE);
    end
  end
  assign o_module_active_flag = busy_q;

  // Read word of the addressed group; global control bit 11 reflects live state, other unimplemented bits stay zero.
  always_comb begin
    rdata_d = DMAGC_ZERO;
    if (hit && !i_wr) begin
      rdata_d = regs[grp] & wmask_of(grp);
      if (grp == DMAGC_GRP_GCTL) begin
        rdata_d[DMAGC_BUSY_BIT] = busy_q;
      end
    end
  end

  // Read data stands for the one cycle after the strobe and is zero otherwise.
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata_q <= DMAGC_ZERO;
    end else begin
      rdata_q <= rdata_d;
    end
  end
  assign o_rdata = rdata_q;
endmodule

// ==== tb_top.sv ====
// Testbench for the DMA global control and CRC register bank.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dmagc_pkg::*;
  logic i_mclk = 1'b0, i_nrst = 1'b0, i_sel = 1'b0, i_wr = 1'b0, i_xfer_req = 1'b0, i_xfer_active = 1'b0;
  logic [15:0] i_addr = 16'h0000;
  logic [31:0] i_wdata = 32'h0000_0000;
  logic [31:0] o_rdata, o_crc_control, o_crc_data, o_crc_xor_mask, rv, m;
  logic o_hit, o_xfer_grant, o_module_on, o_suspend, o_module_active_flag, hv;
  logic [15:0] b;
  int n_errors = 0, n_checks = 0;
  dmagc_top i_dmagc_top (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_sel(i_sel),
    .i_wr(i_wr),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .o_rdata(o_rdata),
    .o_hit(o_hit),
    .i_xfer_req(i_xfer_req),
    .i_xfer_active(i_xfer_active),
    .o_xfer_grant(o_xfer_grant),
    .o_module_on(o_module_on),
    .o_suspend(o_suspend),
    .o_module_active_flag(o_module_active_flag),
    .o_crc_control(o_crc_control),
    .o_crc_data(o_crc_data),
    .o_crc_xor_mask(o_crc_xor_mask)
  );
  initial forever #20 i_mclk = ~i_mclk;
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One strobe per access; the hit flag is sampled while the strobe is up.
  task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    i_sel <= 1'b1;
    i_wr <= w;
    i_addr <= a;
    i_wdata <= d;
    #1 hv = o_hit;
    @(posedge i_mclk);
    i_sel <= 1'b0;
    #1 rv = o_rdata;
  endtask
  task automatic t_reset;
    acc(1'b0, 16'h3000, 32'h0);
    chk("gctl", rv, 32'h0000_0000);
    chk("hit", 32'(hv), 32'h0000_0001);
    acc(1'b0, 16'h3040, 32'h0);
    chk("data", rv, 32'h0000_0000);
    acc(1'b0, 16'h3050, 32'h0);
    chk("xor", rv, 32'h0000_0000);
  endtask
  task automatic t_gctl;
    acc(1'b1, 16'h3000, 32'hFFFF_FFFF);
    acc(1'b0, 16'h3000, 32'h0);
    chk("gctl", rv, 32'h0000_9800);
    acc(1'b1, 16'h3004, 32'h0000_1000);
    acc(1'b0, 16'h3000, 32'h0);
    chk("gctl", rv, 32'h0000_8800);
    acc(1'b1, 16'h300C, 32'h0000_8000);
    acc(1'b0, 16'h3000, 32'h0);
    chk("gctl", rv, 32'h0000_0000);
  endtask
  task automatic t_crc;
    for (int i = 0; i < 3; i++) begin
      b = 16'h3030 + 16'(i) * 16'h0010;
      m = (i == 0) ? DMAGC_CRCCTL_WMASK : 32'hFFFF_FFFF;
      acc(1'b1, b, 32'hA5A5_F00F);
      acc(1'b1, b + 16'h0008, 32'h0000_0FF0);
      acc(1'b1, b + 16'h0004, 32'h0000_00FF);
      acc(1'b1, b + 16'h000C, 32'hFFFF_0000);
      acc(1'b0, b, 32'h0);
      chk("crc", rv, m & 32'h5A5A_FF00);
      case (i)
        0: rv = o_crc_control;
        1: rv = o_crc_data;
        default: rv = o_crc_xor_mask;
      endcase
      chk("crc port", rv, m & 32'h5A5A_FF00);
    end
    acc(1'b1, 16'h3010, 32'hFFFF_FFFF);
    chk("hit", 32'(hv), 32'h0000_0000);
  endtask
  task automatic t_xfer;
    acc(1'b1, 16'h3008, 32'h0000_8000);
    @(posedge i_mclk);
    i_xfer_req <= 1'b1;
    i_xfer_active <= 1'b1;
    #1 chk("grant", 32'(o_xfer_grant), 32'h0000_0001);
    acc(1'b1, 16'h3008, 32'h0000_1000);
    chk("grant", 32'(o_xfer_grant), 32'h0000_0000);
    acc(1'b1, 16'h3004, 32'h0000_9000);
    chk("grant", 32'(o_xfer_grant), 32'h0000_0000);
    // Software leaves the register port idle for two cycles after clearing the enable.
    @(posedge i_mclk);
    acc(1'b0, 16'h3000, 32'h0);
    chk("gctl", rv, 32'h0000_0800);
    @(posedge i_mclk);
    i_xfer_active <= 1'b0;
    acc(1'b0, 16'h3000, 32'h0);
    chk("gctl", rv, 32'h0000_0000);
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge i_mclk);
    i_nrst <= 1'b1;
    t_reset();
    t_gctl();
    t_crc();
    t_xfer();
    conclude();
  end
endmodule
bind dmagc_top dmagc_monitor i_dmagc_monitor (
  .i_mclk(i_mclk),
  .i_nrst(i_nrst),
  .i_sel(i_sel),
  .i_wr(i_wr),
  .i_addr(i_addr),
  .i_wdata(i_wdata),
  .i_xfer_req(i_xfer_req),
  .i_xfer_active(i_xfer_active),
  .o_xfer_grant(o_xfer_grant),
  .o_module_on(o_module_on),
  .o_suspend(o_suspend),
  .o_module_active_flag(o_module_active_flag),
  .o_hit(o_hit),
  .o_rdata(o_rdata)
);
